// file: hdl/sdh_dma_pkg.sv
`default_nettype none
package sdh_dma_pkg;

  // Register offsets that the engine itself serves or decodes.
  localparam logic [11:0] OFF_RESP0       = 12'h030;
  localparam logic [11:0] OFF_RESP1       = 12'h034;
  localparam logic [11:0] OFF_RESP2       = 12'h038;
  localparam logic [11:0] OFF_RESP3       = 12'h03C;
  localparam logic [11:0] OFF_MASKED_IRQ  = 12'h040;
  localparam logic [11:0] OFF_CTRL_STATUS = 12'h048;
  localparam logic [11:0] OFF_CARD_DETECT = 12'h050;
  localparam logic [11:0] OFF_WR_PROTECT  = 12'h054;
  localparam logic [11:0] OFF_CARD_BYTES  = 12'h05C;
  localparam logic [11:0] OFF_HOST_BYTES  = 12'h060;
  localparam logic [11:0] OFF_POLL_DEMAND = 12'h084;
  localparam logic [11:0] OFF_DMA_STATUS  = 12'h08C;
  localparam logic [11:0] OFF_CUR_DESC    = 12'h094;
  localparam logic [11:0] OFF_CUR_BUF     = 12'h098;

  // Read-only or write-only words; they hold no storage of their own.
  localparam int NUM_RO = 14;
  localparam logic [11:0] RO_OFFSETS [NUM_RO] = '{
    OFF_RESP0, OFF_RESP1, OFF_RESP2, OFF_RESP3, OFF_MASKED_IRQ,
    OFF_CTRL_STATUS, OFF_CARD_DETECT, OFF_WR_PROTECT, OFF_CARD_BYTES,
    OFF_HOST_BYTES, OFF_POLL_DEMAND, OFF_DMA_STATUS, OFF_CUR_DESC,
    OFF_CUR_BUF};

  // Plain read/write words, in storage order: control, dividers, source,
  // clock enable, timeout, bus width, block size, byte count, mask,
  // argument, command, raw status, thresholds, debounce, scratch, card
  // reset, bus mode, list base, interrupt enable, clock phase.
  localparam int NUM_RW = 20;
  localparam logic [11:0] RW_OFFSETS [NUM_RW] = '{
    12'h000, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C,
    12'h020, 12'h024, 12'h028, 12'h02C, 12'h044, 12'h04C, 12'h064,
    12'h068, 12'h078, 12'h080, 12'h088, 12'h090, 12'h800};
  localparam logic [4:0] IX_BUS_MODE  = 5'h10;
  localparam logic [4:0] IX_LIST_BASE = 5'h11;
  localparam logic [4:0] IX_IRQ_EN    = 5'h12;
  localparam logic [4:0] IX_PHASE     = 5'h13;
  localparam int         BM_ENABLE    = 7;

  // Descriptor word zero fields, and the top bit of the size field in word one.
  localparam int OWN_BIT    = 31;
  localparam int RING_END   = 5;
  localparam int LINKED     = 4;
  localparam int FINAL_BUF  = 2;
  localparam int NO_CMPL_IR = 1;
  localparam int SIZE_MSB   = 12;

  // Engine status bits; summaries are computed, never stored.
  localparam int STS_W    = 10;
  localparam int ST_TX    = 0;
  localparam int ST_RX    = 1;
  localparam int ST_BUS   = 2;
  localparam int ST_UNAV  = 4;
  localparam int ST_CARD  = 5;
  localparam int ST_NORM  = 8;
  localparam int ST_ABN   = 9;
  localparam logic [STS_W-1:0] NORMAL_MASK   = 10'h003;
  localparam logic [STS_W-1:0] ABNORMAL_MASK = 10'h034;

  // Addressing and bus encodings.
  localparam logic [31:0] WORD_BYTES   = 32'h0000_0004;
  localparam logic [31:0] DESC_STRIDE  = 32'h0000_0010;
  localparam logic [12:0] WORD_BYTES13 = 13'h0004;
  localparam logic [12:0] BURST_BYTES  = 13'h0010;
  localparam logic [2:0]  BURST_REST   = 3'h3;
  localparam logic [1:0]  LAST_WORD    = 2'h3;
  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  HTRANS_BUSY   = 2'h1;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  localparam logic [2:0]  HBURST_SINGLE = 3'h0;
  localparam logic [2:0]  HBURST_INCR4  = 3'h3;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hburst;
    logic [2:0]  hsize;
  } ahb_req_t;

  typedef enum logic [6:0] {
    S_IDLE     = 7'b0000001,
    S_FETCH    = 7'b0000010,
    S_CHECK    = 7'b0000100,
    S_SUSPEND  = 7'b0001000,
    S_WAIT_CMD = 7'b0010000,
    S_XFER     = 7'b0100000,
    S_WRBACK   = 7'b1000000
  } fsm_t;

endpackage : sdh_dma_pkg
`default_nettype wire

// file: hdl/card_host_descriptor_dma.sv
`timescale 1ns/1ps
`default_nettype none
module card_host_descriptor_dma #(
  parameter int BUF_DEPTH = 2
) (
  // Clock, reset and clock enable.
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  // Register port.
  input  wire sdh_dma_pkg::apb_req_t i_apb,
  output logic [31:0]                o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // Memory master.
  output sdh_dma_pkg::ahb_req_t      o_ahb,
  output logic [31:0]                o_hwdata,
  input  wire logic [31:0]           i_hrdata,
  input  wire logic                  i_hready,
  input  wire logic                  i_hresp,
  // Bus interface unit.
  input  wire logic                  i_command_done,
  input  wire logic                  i_biu_error,
  input  wire logic                  i_dir_transmit,
  input  wire logic                  i_fifo_transfer_request,
  // Controller FIFO.
  output logic [31:0]                o_fifo_wdata,
  output logic                       o_fifo_wvalid,
  input  wire logic                  i_fifo_wready,
  input  wire logic [31:0]           i_fifo_rdata,
  input  wire logic                  i_fifo_rvalid,
  output logic                       o_fifo_rready,
  // Card side and interrupt.
  output logic [31:0]                o_clock_phase_select,
  output logic                       o_dma_interrupt
);
  import sdh_dma_pkg::*;

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  if (BUF_DEPTH < 2 || BUF_DEPTH > 256 ||
      (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("BUF_DEPTH must be a power of two from 2 to 256");
  end

  typedef struct packed {
    logic [NUM_RW-1:0][31:0]    regs;
    fsm_t                       st;
    logic [STS_W-1:0]           sts;
    logic                       armed;
    logic                       cmd_ok;
    logic                       dir_tx;
    logic                       ap;
    logic                       dp;
    logic                       dp_wr;
    logic [1:0]                 beat;
    logic [2:0]                 burst_left;
    logic [3:0][31:0]           des;
    logic [31:0]                desc_addr;
    logic [31:0]                buf_addr;
    logic [31:0]                moved;
    logic [12:0]                remain;
    logic [BUF_DEPTH-1:0][31:0] mem;
    logic [PW-1:0]              rp;
    logic [PW-1:0]              wp;
    logic [PW:0]                cnt;
    ahb_req_t                   ahb;
    logic [31:0]                hwdata;
    logic [31:0]                prdata;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [5:0] rw_find(input logic [11:0] a);
    logic [5:0] r;
    r = '0;
    for (int i = 0; i < NUM_RW; i++)
      if (RW_OFFSETS[i] == a)
        r = {1'b1, 5'(i)};
    return r;
  endfunction : rw_find

  function automatic logic ro_find(input logic [11:0] a);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_RO; i++)
      if (RO_OFFSETS[i] == a)
        r = 1'b1;
    return r;
  endfunction : ro_find

  function automatic ahb_req_t make_req(input logic [31:0] a,
                                        input logic        w,
                                        input logic [1:0]  t,
                                        input logic [2:0]  b);
    ahb_req_t r;
    r.haddr  = a;
    r.hwrite = w;
    r.htrans = t;
    r.hburst = b;
    r.hsize  = HSIZE_WORD;
    return r;
  endfunction : make_req

  logic             wr_acc;
  logic             poll;
  logic             busy;
  logic             dp_done;
  logic             bus_err;
  logic             push;
  logic             pop;
  logic             push_tx;
  logic             start_burst;
  logic             use_incr4;
  logic             normal_summary;
  logic             abnormal_summary;
  logic [5:0]       wsel;
  logic [5:0]       rsel;
  logic [31:0]      en;
  logic [31:0]      rdval;
  logic [31:0]      next_desc;
  logic [12:0]      cnt13;
  logic [STS_W-1:0] sts_set;
  logic [STS_W-1:0] sts_clr;

  // Summaries only look at enabled events; sticky bits mean a repeat of a
  // pending event cannot raise a second interrupt.
  assign en              = q.regs[IX_IRQ_EN];
  assign normal_summary             = |(q.sts & en[STS_W-1:0] & NORMAL_MASK);
  assign abnormal_summary             = |(q.sts & en[STS_W-1:0] & ABNORMAL_MASK);
  assign o_dma_interrupt = normal_summary | abnormal_summary;
  assign o_pready        = i_ce;
  assign o_pslverr       = i_apb.psel & i_apb.penable &
                           ~wsel[5] & ~ro_find(i_apb.paddr);
  assign o_prdata        = q.prdata;
  assign o_ahb           = q.ahb;
  assign o_hwdata        = q.hwdata;
  assign o_fifo_wdata    = q.mem[q.rp];
  assign o_fifo_wvalid   = i_ce & q.dir_tx & (q.cnt != '0);
  assign o_clock_phase_select = q.regs[IX_PHASE];
  assign cnt13           = 13'(q.cnt);
  assign o_fifo_rready   = i_ce & ~q.dir_tx & (q.st == S_XFER) &
                           (cnt13 < 13'(BUF_DEPTH)) &
                           (cnt13 < {2'b00, q.remain[12:2]});

  always_comb
  begin
    d       = q;
    sts_set = '0;
    sts_clr = '0;
    wr_acc  = i_apb.psel & i_apb.penable & i_apb.pwrite;
    wsel    = rw_find(i_apb.paddr);
    rsel    = wsel;
    poll    = wr_acc & (i_apb.paddr == OFF_POLL_DEMAND);
    busy    = q.ap | q.dp;
    dp_done = q.dp & i_hready;
    bus_err = dp_done & i_hresp;
    start_burst = (q.burst_left == '0);
    use_incr4   = (q.remain >= BURST_BYTES) & (q.buf_addr[3:0] == 4'h0);
    next_desc   = q.desc_addr + DESC_STRIDE;

    // Register writes and the read data captured in the setup phase.
    if (wr_acc && wsel[5])
      d.regs[wsel[4:0]] = i_apb.pwdata;
    if (wr_acc && wsel[5] && wsel[4:0] == IX_LIST_BASE)
    begin
      d.armed     = 1'b1;
      d.desc_addr = i_apb.pwdata;
    end
    if (wr_acc && i_apb.paddr == OFF_DMA_STATUS)
      sts_clr = i_apb.pwdata[STS_W-1:0];
    rdval = '0;
    if (i_apb.paddr == OFF_DMA_STATUS)
    begin
      rdval[STS_W-1:0] = q.sts;
      rdval[ST_NORM]   = normal_summary;
      rdval[ST_ABN]    = abnormal_summary;
    end
    else if (i_apb.paddr == OFF_CUR_DESC)
      rdval = q.desc_addr;
    else if (i_apb.paddr == OFF_CUR_BUF)
      rdval = q.buf_addr;
    else if (i_apb.paddr == OFF_HOST_BYTES)
      rdval = q.moved;
    else if (rsel[5])
      rdval = q.regs[rsel[4:0]];
    if (i_apb.psel && !i_apb.penable)
      d.prdata = rdval;

    // Address phase taken: go to data phase, keep a burst open with BUSY.
    if (q.ap && i_hready)
    begin
      d.ap         = 1'b0;
      d.dp         = 1'b1;
      d.ahb.htrans = (q.burst_left != '0) ? HTRANS_BUSY : HTRANS_IDLE;
    end
    if (dp_done)
      d.dp = 1'b0;

    unique case (q.st)
      S_IDLE:
      begin
        if (q.armed && q.regs[IX_BUS_MODE][BM_ENABLE])
        begin
          d.st   = S_FETCH;
          d.beat = '0;
        end
      end
      S_FETCH:
      begin
        if (!busy)
        begin
          d.ap    = 1'b1;
          d.dp_wr = 1'b0;
          d.ahb   = make_req(q.desc_addr + 32'({q.beat, 2'b00}), 1'b0,
                             HTRANS_NONSEQ, HBURST_SINGLE);
        end
        if (dp_done)
        begin
          d.des[q.beat] = i_hrdata;
          d.beat        = q.beat + 2'h1;
          if (q.beat == LAST_WORD)
            d.st = S_CHECK;
        end
      end
      S_CHECK:
      begin
        if (!q.des[0][OWN_BIT])
        begin
          sts_set[ST_UNAV] = 1'b1;
          d.st             = S_SUSPEND;
        end
        else
        begin
          d.buf_addr = q.des[2];
          d.remain   = q.des[1][SIZE_MSB:0];
          d.dir_tx   = i_dir_transmit;
          d.st       = q.cmd_ok ? S_XFER : S_WAIT_CMD;
        end
      end
      S_SUSPEND:
      begin
        if (poll)
        begin
          d.st   = S_FETCH;
          d.beat = '0;
        end
      end
      S_WAIT_CMD:
      begin
        if (i_biu_error)
        begin
          sts_set[ST_CARD] = 1'b1;
          d.armed          = 1'b0;
          d.st             = S_IDLE;
        end
        else if (i_command_done)
        begin
          d.cmd_ok = 1'b1;
          d.st     = S_XFER;
        end
      end
      S_XFER:
      begin
        if (!busy && q.remain == '0)
          d.st = S_WRBACK;
        else if (!busy &&
                 (!start_burst || i_fifo_transfer_request) &&
                 (q.dir_tx ? (q.cnt < (PW+1)'(BUF_DEPTH))
                           : (q.cnt != '0)))
        begin
          d.ap     = 1'b1;
          d.dp_wr  = ~q.dir_tx;
          d.hwdata = q.mem[q.rp];
          d.ahb    = make_req(q.buf_addr, ~q.dir_tx,
                              start_burst ? HTRANS_NONSEQ : HTRANS_SEQ,
                              start_burst ?
                                (use_incr4 ? HBURST_INCR4 : HBURST_SINGLE)
                                : q.ahb.hburst);
          d.burst_left = start_burst ?
                           (use_incr4 ? BURST_REST : 3'h0)
                           : q.burst_left - 3'h1;
          d.buf_addr   = q.buf_addr + WORD_BYTES;
          d.remain     = q.remain - WORD_BYTES13;
          d.moved      = q.moved + WORD_BYTES;
        end
      end
      S_WRBACK:
      begin
        if (!busy)
        begin
          d.ap     = 1'b1;
          d.dp_wr  = 1'b1;
          d.hwdata = q.des[0];
          d.hwdata[OWN_BIT] = 1'b0;
          d.ahb    = make_req(q.desc_addr, 1'b1, HTRANS_NONSEQ,
                              HBURST_SINGLE);
        end
        if (dp_done)
        begin
          if (q.des[0][RING_END])
            d.desc_addr = q.regs[IX_LIST_BASE];
          else if (q.des[0][LINKED])
            d.desc_addr = q.des[3];
          else
            d.desc_addr = next_desc;
          if (q.des[0][FINAL_BUF])
          begin
            d.cmd_ok = 1'b0;
            if (!q.des[0][NO_CMPL_IR])
            begin
              sts_set[ST_TX] = q.dir_tx & en[ST_TX];
              sts_set[ST_RX] = ~q.dir_tx & en[ST_RX];
            end
          end
          d.st   = S_FETCH;
          d.beat = '0;
        end
      end
    endcase

    // An error response ends the transfer and parks the engine.
    if (bus_err)
    begin
      sts_set[ST_BUS] = 1'b1;
      d.armed         = 1'b0;
      d.st            = S_IDLE;
      d.ap            = 1'b0;
      d.burst_left    = '0;
      d.ahb.htrans    = HTRANS_IDLE;
    end

    // BUF_DEPTH-entry buffer (two by default) between memory and the controller FIFO.
    push_tx = dp_done & ~bus_err & ~q.dp_wr & q.dir_tx & (q.st == S_XFER);
    push    = push_tx | (o_fifo_rready & i_fifo_rvalid);
    pop     = q.dir_tx ? (o_fifo_wvalid & i_fifo_wready)
                       : (dp_done & ~bus_err & q.dp_wr & (q.st == S_XFER));
    if (push)
    begin
      d.mem[q.wp] = push_tx ? i_hrdata : i_fifo_rdata;
      d.wp        = q.wp + PW'(1);
    end
    if (pop)
      d.rp = q.rp + PW'(1);
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);

    // A new event wins over a clear in the same cycle.
    d.sts = (q.sts & ~sts_clr) | sts_set;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q    <= '0;
      q.st <= S_IDLE;
    end
    else if (i_ce)
      q <= d;
  end

endmodule : card_host_descriptor_dma
`default_nettype wire

// file: sim/card_host_descriptor_dma_props.sv
`timescale 1ns/1ps
`default_nettype none
module card_host_descriptor_dma_props
  import sdh_dma_pkg::*;
(
  // Clock and register port.
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  input wire logic                  i_ce,
  input wire sdh_dma_pkg::apb_req_t i_apb,
  input wire logic [31:0]           o_prdata,
  input wire logic                  o_pready,
  input wire logic                  o_pslverr,
  // Memory master and FIFO ports.
  input wire sdh_dma_pkg::ahb_req_t o_ahb,
  input wire logic [31:0]           o_hwdata,
  input wire logic                  i_hready,
  input wire logic                  i_dir_transmit,
  input wire logic [31:0]           o_fifo_wdata,
  input wire logic                  o_fifo_wvalid,
  input wire logic                  i_fifo_wready,
  input wire logic                  o_fifo_rready,
  // Card side and interrupt.
  input wire logic [31:0]           o_clock_phase_select,
  input wire logic                  o_dma_interrupt
);
  logic        dpw_q;
  logic [31:0] last_q;

  // Tracks write data phases and the last accepted beat address.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dpw_q  <= 1'b0;
      last_q <= 32'h0;
    end
    else if (i_hready && i_ce)
    begin
      dpw_q <= o_ahb.htrans[1] && o_ahb.hwrite;
      if (o_ahb.htrans[1])
        last_q <= o_ahb.haddr;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_access(logic [11:0] a);
    i_apb.psel && i_apb.penable && i_apb.paddr == a;
  endsequence

  a_pready_ce: assert property (o_pready == i_ce)
    else $error("pready differs from clock enable");
  a_unmapped_err: assert property (s_access(12'h004) |-> o_pslverr)
    else $error("no slave error on unmapped access");
  a_phase_write: assert property (
    s_access(12'h800) ##0 (i_apb.pwrite && i_ce)
    |=> o_clock_phase_select == $past(i_apb.pwdata))
    else $error("phase select not updated");
  a_irq_summary: assert property (
    s_access(OFF_DMA_STATUS) ##0 !i_apb.pwrite
    |-> (o_prdata[ST_NORM] || o_prdata[ST_ABN]) == $past(o_dma_interrupt))
    else $error("interrupt differs from summaries");
  a_word_size: assert property (
    o_ahb.htrans[1] |-> o_ahb.hsize == HSIZE_WORD)
    else $error("non word transfer size");
  a_seq_addr: assert property (
    o_ahb.htrans == HTRANS_SEQ |-> o_ahb.haddr == last_q + WORD_BYTES)
    else $error("burst beat address not incrementing");
  a_seq_burst: assert property (
    o_ahb.htrans == HTRANS_SEQ |-> o_ahb.hburst == HBURST_INCR4)
    else $error("sequential beat outside a burst");
  a_wdata_hold: assert property (
    dpw_q && !i_hready |=> $stable(o_hwdata))
    else $error("write data changed in wait state");
  a_wvalid_hold: assert property (
    o_fifo_wvalid && !i_fifo_wready
    |=> o_fifo_wvalid && $stable(o_fifo_wdata))
    else $error("fifo word dropped while stalled");
  a_rx_only: assert property (
    o_fifo_rready |-> !i_dir_transmit)
    else $error("fifo read during transmit");
endmodule : card_host_descriptor_dma_props

bind card_host_descriptor_dma card_host_descriptor_dma_props chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_apb(i_apb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_ahb(o_ahb), .o_hwdata(o_hwdata), .i_hready(i_hready),
  .i_dir_transmit(i_dir_transmit), .o_fifo_wdata(o_fifo_wdata),
  .o_fifo_wvalid(o_fifo_wvalid), .i_fifo_wready(i_fifo_wready),
  .o_fifo_rready(o_fifo_rready),
  .o_clock_phase_select(o_clock_phase_select),
  .o_dma_interrupt(o_dma_interrupt));
`default_nettype wire

// file: sim/ahb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_mem_model
  import sdh_dma_pkg::*;
(
  // Clock, reset and pacing.
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_slow,
  // Bus.
  input  wire sdh_dma_pkg::ahb_req_t i_ahb,
  input  wire logic [31:0]           i_hwdata,
  output logic [31:0]                o_hrdata,
  output logic                       o_hready
);
  logic [31:0] m [256];
  logic        dp_q;
  logic        wr_q;
  logic [7:0]  a_q;
  logic [1:0]  wait_q;
  logic [31:0] last_q;

  // Outside a read data phase the lines show the inverse of the last word.
  always_comb o_hready = !dp_q || wait_q == 2'h0;
  always_comb o_hrdata = (dp_q && !wr_q) ? m[a_q] : ~last_q;

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dp_q   <= 1'b0;
      wr_q   <= 1'b0;
      wait_q <= 2'h0;
      last_q <= 32'h0;
    end
    else if (dp_q && wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
    else
    begin
      if (dp_q && wr_q)
        m[a_q] <= i_hwdata;
      if (dp_q && !wr_q)
        last_q <= m[a_q];
      dp_q   <= i_ahb.htrans[1];
      wr_q   <= i_ahb.hwrite;
      a_q    <= i_ahb.haddr[9:2];
      wait_q <= i_slow ? 2'h2 : 2'h0;
    end
  end
endmodule : ahb_mem_model
`default_nettype wire

// file: sim/card_host_descriptor_dma_test.sv
`timescale 1ns/1ps
`default_nettype none
module card_host_descriptor_dma_test;
  import sdh_dma_pkg::*;
  logic        i_clk, i_rst, i_ce, slow, cmd_done, dir_tx, req;
  logic        wready, rx_on, pready, pslverr, hready, wvalid;
  logic        rvalid, rready, irq, err, berr;
  apb_req_t    apb;
  ahb_req_t    ahb;
  logic [31:0] prdata, hwdata, hrdata, wdata, rdata, rx_k, rd_v, phase;
  logic [31:0] txq [$];
  int          num_errors, check_count, i;

  card_host_descriptor_dma uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_apb(apb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_ahb(ahb), .o_hwdata(hwdata), .i_hrdata(hrdata),
    .i_hready(hready), .i_hresp(1'b0), .i_command_done(cmd_done),
    .i_biu_error(berr), .i_dir_transmit(dir_tx),
    .i_fifo_transfer_request(req), .o_fifo_wdata(wdata),
    .o_fifo_wvalid(wvalid), .i_fifo_wready(wready),
    .i_fifo_rdata(rdata), .i_fifo_rvalid(rvalid),
    .o_fifo_rready(rready), .o_clock_phase_select(phase),
    .o_dma_interrupt(irq));
  ahb_mem_model mem (
    .i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_ahb(ahb),
    .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hready(hready));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // The FIFO sink stalls every other cycle; the source offers three words.
  always @(posedge i_clk)
  begin
    wready <= ~wready;
    if (wvalid && wready)
      txq.push_back(wdata);
    if (rvalid && rready)
      rx_k <= rx_k + 32'h1;
  end
  assign rvalid = rx_on && rx_k < 32'h3;
  assign rdata  = 32'hA500_0000 + rx_k;

  task automatic stop_test;
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    #1;
    apb = '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    #1;
    apb.penable = 1'b1;
    @(posedge i_clk);
    rd_v = prdata;
    err  = pslverr;
    #1;
    apb = '0;
  endtask : bus

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd_v, e);
  endtask : rd

  task automatic wait_sts(input logic [31:0] m);
    for (int n = 0; n < 300; n++)
    begin
      bus(1'b0, OFF_DMA_STATUS, 32'h0);
      if ((rd_v & m) === m)
        return;
    end
    num_errors++;
    stop_test();
  endtask : wait_sts

  task automatic desc(input int w, input logic [31:0] f, s, b, n);
    mem.m[w]   = f;
    mem.m[w+1] = s;
    mem.m[w+2] = b;
    mem.m[w+3] = n;
  endtask : desc

  initial
  begin
    apb = '0;
    i_ce = 1'b1;
    i_rst = 1'b1;
    {slow, cmd_done, req, wready, rx_on, berr} = 6'h00;
    dir_tx = 1'b1;
    rx_k = 32'h0;
    num_errors = 0;
    check_count = 0;
    for (i = 0; i < 256; i++)
      mem.m[i] = 32'h0;
    for (i = 0; i < 7; i++)
      mem.m[(i < 5) ? 64 + i : 91 + i] = 32'hC0DE_0000 + i;
    desc(0, 32'h8000_0010, 32'h14, 32'h100, 32'h40);
    desc(16, 32'h8000_0004, 32'h8, 32'h180, 32'h0);
    repeat (8) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    rd(12'h000, 32'h0);
    bus(1'b1, 12'h068, 32'hA5A5_5A5A);
    rd(12'h068, 32'hA5A5_5A5A);
    bus(1'b1, 12'h800, 32'h0000_0003);
    check(phase, 32'h3);
    bus(1'b1, OFF_RESP0, 32'hFFFF_FFFF);
    rd(OFF_RESP0, 32'h0);
    bus(1'b0, 12'h004, 32'h0);
    check({31'h0, err}, 32'h1);
    bus(1'b1, 12'h080, 32'h80);
    bus(1'b1, 12'h090, 32'h13);
    bus(1'b1, 12'h088, 32'h0);
    repeat (60) @(posedge i_clk);
    check(32'(txq.size()), 32'h0);
    #1;
    cmd_done = 1'b1;
    repeat (30) @(posedge i_clk);
    check(32'(txq.size()), 32'h0);
    #1;
    req = 1'b1;
    wait_sts(32'h11);
    rd(OFF_DMA_STATUS, 32'h311);
    check({31'h0, irq}, 32'h1);
    check(32'(txq.size()), 32'h7);
    for (i = 0; i < 7; i++)
      check(txq[i], 32'hC0DE_0000 + i);
    check(mem.m[0], 32'h0000_0010);
    check(mem.m[16], 32'h0000_0004);
    bus(1'b1, OFF_DMA_STATUS, 32'h002);
    rd(OFF_DMA_STATUS, 32'h311);
    bus(1'b1, OFF_DMA_STATUS, 32'h011);
    rd(OFF_DMA_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    desc(20, 32'h8000_0000, 32'h4, 32'h200, 32'h0);
    desc(24, 32'h8000_0026, 32'h8, 32'h210, 32'h0);
    dir_tx = 1'b0;
    slow = 1'b1;
    rx_on = 1'b1;
    bus(1'b1, OFF_POLL_DEMAND, 32'hDEAD_BEEF);
    wait_sts(32'h10);
    rd(OFF_DMA_STATUS, 32'h210);
    rd(OFF_CUR_DESC, 32'h0);
    check(mem.m[128], 32'hA500_0000);
    check(mem.m[132], 32'hA500_0001);
    check(mem.m[133], 32'hA500_0002);
    check(mem.m[24], 32'h0000_0026);
    bus(1'b1, 12'h090, 32'h003);
    rd(OFF_DMA_STATUS, 32'h010);
    check({31'h0, irq}, 32'h0);
    desc(0, 32'h8000_0004, 32'h4, 32'h300, 32'h0);
    cmd_done = 1'b0;
    berr = 1'b1;
    bus(1'b1, OFF_POLL_DEMAND, 32'h0);
    wait_sts(32'h20);
    rd(OFF_DMA_STATUS, 32'h030);
    check(mem.m[0], 32'h8000_0004);
    check(mem.m[192], 32'h0);
    stop_test();
  end
endmodule : card_host_descriptor_dma_test
`default_nettype wire
